// file: core/cpu_flag_core.sv
// status word, decimal arithmetic, multiply and divide of the cpu core
// Function
// - reset sets the interrupt mask flag of the status word; other flags may be anything.
// - a written interrupt request value need only show to bit tests after one more instruction.
// - with the base-ten flag set, add and subtract work in packed decimal.
// - sign, overflow and zero flags carry no meaning after decimal arithmetic.
// - results of decimal arithmetic hold once a later instruction sets or clears carry or base-ten.
// - multiply and divide ignore the index-X mode and base-ten flags.
// - multiply and divide leave the whole status word unchanged.
// - an instruction lasts its cycle count times the cycle clock period.
// - in high-speed mode the cycle clock is the main oscillator input divided by two.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_flag_regs.svh"
module cpu_flag_core (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // register port
  input wire logic [2:0] ADDR_IN,
  input wire cpu_flag_pkg::byte_t WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output var cpu_flag_pkg::byte_t RDATA_OUT,
  // status
  output logic BUSY_OUT,
  output var cpu_flag_pkg::byte_t PSW_OUT,
  output logic PHI_OUT
);
  import cpu_flag_pkg::*;

  logic rst_s1_r;
  logic rst_n_r;
  exec_state_t state_r;
  byte_t acc_r;
  byte_t memx_r;
  byte_t opnd_r;
  byte_t high_r;
  byte_t psw_r;
  byte_t psw_nxt;
  byte_t ctrl_r;
  byte_t irq_pend_r;
  byte_t irq_stage_r;
  byte_t irq_vis_r;
  byte_t rdata_r;
  byte_t op_a_r;
  byte_t op_b_r;
  byte_t op_h_r;
  byte_t alu_res;
  byte_t add_sum;
  opcode_t op_r;
  logic [4:0] cnt_r;
  logic xmode_r;
  logic taken_r;
  logic busy;
  logic issue;
  logic done;
  logic tick;
  logic add_c;
  logic add_v;
  logic [15:0] product;
  logic [15:0] dividend;
  logic [15:0] quot;
  logic [15:0] remd;

  function automatic logic hit(input logic s, input logic [2:0] a, input logic [2:0] w);
    hit = s && (a == w);
  endfunction

  function automatic logic is_alu(input opcode_t op);
    is_alu = (op >= `OP_ADD_CARRY) && (op <= `OP_XOR);
  endfunction

  function automatic logic [4:0] cycles(input opcode_t op, input logic t);
    case (op)
      `OP_PRODUCT: cycles = `CYC_MUL;
      `OP_QUOTIENT: cycles = `CYC_DIV;
      `OP_BRANCH_SET, `OP_BRANCH_CLR: cycles = `CYC_BB;
      default: cycles = (is_alu(op) && t) ? `CYC_BASE + `CYC_T_EXTRA : `CYC_BASE;
    endcase
  endfunction

  function automatic logic bcd_ok(input byte_t v);
    bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9);
  endfunction

  // reset released through two flip-flops
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  assign busy = (state_r == ST_EXEC);
  assign issue = hit(WR_IN, ADDR_IN, `OFF_CMD) && !busy;
  // completion lands exactly on the last cycle clock tick
  assign done = busy && tick && (cnt_r == 5'h01);

  phi_divider u_phi (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(rst_n_r),
    .high_speed_in(ctrl_r[`CTRL_HS]),
    .restart_in(issue),
    .tick_out(tick)
  );

  bcd_adder u_add (
    .a_in(op_a_r),
    .b_in(op_b_r),
    .carry_in(psw_r[`PSW_C]),
    .sub_in(op_r == `OP_SUB_BORROW),
    .dec_in(psw_r[`PSW_D]),
    .sum_out(add_sum),
    .carry_out(add_c),
    .ovf_out(add_v)
  );

  // multiply and divide see only the captured operands
  assign product = op_a_r * op_b_r;
  assign dividend = {op_h_r, op_a_r};
  assign quot = (op_b_r == 8'h00) ? 16'h00FF : dividend / {8'h00, op_b_r};
  assign remd = (op_b_r == 8'h00) ? {8'h00, op_h_r} : dividend % {8'h00, op_b_r};

  always_comb begin
    case (op_r)
      `OP_AND: alu_res = op_a_r & op_b_r;
      `OP_OR: alu_res = op_a_r | op_b_r;
      `OP_XOR: alu_res = op_a_r ^ op_b_r;
      default: alu_res = add_sum;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: if (issue) state_r <= ST_EXEC;
        ST_EXEC: if (done) state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // cycle count in cycle clock periods
  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt_r <= 5'h00;
    end else if (issue) begin
      cnt_r <= cycles(WDATA_IN[4:0], psw_r[`PSW_T]);
    end else if (busy && tick) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  // operands captured at issue so late writes cannot disturb a result
  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      op_r <= `OP_NOP;
      op_a_r <= 8'h00;
      op_b_r <= 8'h00;
      op_h_r <= 8'h00;
      xmode_r <= 1'b0;
    end else if (issue) begin
      op_r <= WDATA_IN[4:0];
      xmode_r <= psw_r[`PSW_T] && is_alu(WDATA_IN[4:0]);
      op_a_r <= (psw_r[`PSW_T] && is_alu(WDATA_IN[4:0])) ? memx_r : acc_r;
      op_b_r <= opnd_r;
      op_h_r <= high_r;
    end
  end

  // a write to acc, memx, operand, high or psw while busy is dropped
  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      acc_r <= 8'h00;
    end else if (done && is_alu(op_r) && !xmode_r) begin
      acc_r <= alu_res;
    end else if (done && op_r == `OP_PRODUCT) begin
      acc_r <= product[7:0];
    end else if (done && op_r == `OP_QUOTIENT) begin
      acc_r <= quot[7:0];
    end else if (hit(WR_IN, ADDR_IN, `OFF_ACC) && !busy) begin
      acc_r <= WDATA_IN;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      memx_r <= 8'h00;
    end else if (done && xmode_r) begin
      memx_r <= alu_res;
    end else if (hit(WR_IN, ADDR_IN, `OFF_MEMX) && !busy) begin
      memx_r <= WDATA_IN;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      opnd_r <= 8'h00;
    end else if (hit(WR_IN, ADDR_IN, `OFF_OPND) && !busy) begin
      opnd_r <= WDATA_IN;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      high_r <= 8'h00;
    end else if (done && op_r == `OP_PRODUCT) begin
      high_r <= product[15:8];
    end else if (done && op_r == `OP_QUOTIENT) begin
      high_r <= remd[7:0];
    end else if (hit(WR_IN, ADDR_IN, `OFF_HIGH) && !busy) begin
      high_r <= WDATA_IN;
    end
  end

  always_comb begin
    psw_nxt = psw_r;
    case (op_r)
      `OP_ADD_CARRY, `OP_SUB_BORROW: begin
        // flags written as for binary; sign, overflow, zero unreliable in decimal
        psw_nxt[`PSW_C] = add_c;
        psw_nxt[`PSW_V] = add_v;
        psw_nxt[`PSW_N] = alu_res[7];
        psw_nxt[`PSW_Z] = (alu_res == 8'h00);
      end
      `OP_AND, `OP_OR, `OP_XOR: begin
        psw_nxt[`PSW_N] = alu_res[7];
        psw_nxt[`PSW_Z] = (alu_res == 8'h00);
      end
      // carry and base-ten edits act on settled flags
      `OP_CARRY_SET: psw_nxt[`PSW_C] = 1'b1;
      `OP_CARRY_CLR: psw_nxt[`PSW_C] = 1'b0;
      `OP_TEN_SET: psw_nxt[`PSW_D] = 1'b1;
      `OP_TEN_CLR: psw_nxt[`PSW_D] = 1'b0;
      `OP_XMODE_SET: psw_nxt[`PSW_T] = 1'b1;
      `OP_XMODE_CLR: psw_nxt[`PSW_T] = 1'b0;
      `OP_IMASK_SET: psw_nxt[`PSW_I] = 1'b1;
      `OP_IMASK_CLR: psw_nxt[`PSW_I] = 1'b0;
      // product and quotient keep the word as it is
      default: psw_nxt = psw_r;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      psw_r <= `PSW_RST;
    end else if (done) begin
      psw_r <= psw_nxt;
    end else if (hit(WR_IN, ADDR_IN, `OFF_PSW) && !busy) begin
      psw_r <= WDATA_IN;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= `CTRL_RST;
    end else if (hit(WR_IN, ADDR_IN, `OFF_CTRL)) begin
      ctrl_r <= WDATA_IN;
    end
  end

  // request writes pass a stage; bit tests see them one instruction later
  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_pend_r <= 8'h00;
      irq_stage_r <= 8'h00;
      irq_vis_r <= 8'h00;
    end else begin
      if (hit(WR_IN, ADDR_IN, `OFF_IRQ)) irq_pend_r <= WDATA_IN;
      if (issue) irq_stage_r <= irq_pend_r;
      if (done) irq_vis_r <= irq_stage_r;
    end
  end

  // bit test picks its bit from ctrl[3:1]
  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      taken_r <= 1'b0;
    end else if (done && op_r == `OP_BRANCH_SET) begin
      taken_r <= irq_vis_r[ctrl_r[3:1]];
    end else if (done && op_r == `OP_BRANCH_CLR) begin
      taken_r <= !irq_vis_r[ctrl_r[3:1]];
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= 8'h00;
    end else if (RD_IN) begin
      case (ADDR_IN)
        `OFF_ACC: rdata_r <= acc_r;
        `OFF_MEMX: rdata_r <= memx_r;
        `OFF_OPND: rdata_r <= opnd_r;
        `OFF_PSW: rdata_r <= psw_r;
        `OFF_HIGH: rdata_r <= high_r;
        `OFF_IRQ: rdata_r <= irq_vis_r;
        `OFF_CMD: rdata_r <= {6'h00, taken_r, busy};
        default: rdata_r <= ctrl_r;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign RDATA_OUT = rdata_r;
  assign BUSY_OUT = busy;
  assign PSW_OUT = psw_r;
  assign PHI_OUT = tick;

  // helper: clocks spent since issue
  logic [7:0] exec_clks_r;
  logic [4:0] cyc_r;
  logic hs_at_r;
  always_ff @(posedge CLK_SYS_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      exec_clks_r <= 8'h00;
      cyc_r <= 5'h00;
      hs_at_r <= 1'b0;
    end else if (issue) begin
      exec_clks_r <= 8'h00;
      cyc_r <= cycles(WDATA_IN[4:0], psw_r[`PSW_T]);
      hs_at_r <= ctrl_r[`CTRL_HS];
    end else if (busy) begin
      exec_clks_r <= exec_clks_r + 8'h01;
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!rst_n_r);

  a_reset_imask: assert property ($rose(rst_n_r) |-> psw_r[`PSW_I])
    else $error("interrupt mask not set after reset");
  a_irq_late: assert property (hit(WR_IN, ADDR_IN, `OFF_IRQ) && !done |=>
    irq_vis_r == $past(irq_vis_r))
    else $error("request write visible at once");
  a_dec_digits: assert property (done && op_r == `OP_ADD_CARRY && psw_r[`PSW_D]
    && !xmode_r && bcd_ok(op_a_r) && bcd_ok(op_b_r) |=> bcd_ok(acc_r))
    else $error("decimal add gave a non-decimal digit");
  a_flag_edit: assert property (done && op_r == `OP_CARRY_CLR |=>
    !psw_r[`PSW_C])
    else $error("carry clear lost");
  a_mul_result: assert property (done && op_r == `OP_PRODUCT |=>
    {high_r, acc_r} == 16'(op_a_r) * 16'(op_b_r))
    else $error("product wrong");
  a_psw_hold: assert property (done && (op_r == `OP_PRODUCT ||
    op_r == `OP_QUOTIENT) |=> $stable(psw_r))
    else $error("status word changed by multiply or divide");
  a_exec_time: assert property (done |-> int'(exec_clks_r) + 1 ==
    int'(cyc_r) * (hs_at_r ? int'(`DIV_HIGH) : int'(`DIV_MID)))
    else $error("instruction time wrong");
  a_phi_half: assert property (tick && ctrl_r[`CTRL_HS] |=> !tick)
    else $error("cycle clock not divided by two");
  a_xmode_dest: assert property (done && xmode_r |=> $stable(acc_r) &&
    memx_r == $past(alu_res))
    else $error("index-X result misplaced");

  c_mul_done: cover property (done && op_r == `OP_PRODUCT);
  c_dec_sub: cover property (done && op_r == `OP_SUB_BORROW && psw_r[`PSW_D]);
  c_branch_taken: cover property (done && op_r == `OP_BRANCH_SET ##1 taken_r);
endmodule
`default_nettype wire

// file: core/cpu_flag_regs.svh
// register offsets, status bit positions, opcodes and cycle counts
`ifndef CPU_FLAG_REGS_SVH
`define CPU_FLAG_REGS_SVH
`define OFF_ACC 3'h0
`define OFF_MEMX 3'h1
`define OFF_OPND 3'h2
`define OFF_PSW 3'h3
`define OFF_HIGH 3'h4
`define OFF_IRQ 3'h5
`define OFF_CMD 3'h6
`define OFF_CTRL 3'h7
`define PSW_C 0
`define PSW_Z 1
`define PSW_I 2
`define PSW_D 3
`define PSW_B 4
`define PSW_T 5
`define PSW_V 6
`define PSW_N 7
`define PSW_RST 8'h04
`define CTRL_RST 8'h01
`define CTRL_HS 0
`define OP_NOP 5'h00
`define OP_ADD_CARRY 5'h01
`define OP_SUB_BORROW 5'h02
`define OP_AND 5'h03
`define OP_OR 5'h04
`define OP_XOR 5'h05
`define OP_CARRY_SET 5'h06
`define OP_CARRY_CLR 5'h07
`define OP_TEN_SET 5'h08
`define OP_TEN_CLR 5'h09
`define OP_XMODE_SET 5'h0A
`define OP_XMODE_CLR 5'h0B
`define OP_IMASK_SET 5'h0C
`define OP_IMASK_CLR 5'h0D
`define OP_PRODUCT 5'h0E
`define OP_QUOTIENT 5'h0F
`define OP_BRANCH_SET 5'h10
`define OP_BRANCH_CLR 5'h11
`define CYC_BASE 5'h02
`define CYC_T_EXTRA 5'h03
`define CYC_MUL 5'h0F
`define CYC_DIV 5'h10
`define CYC_BB 5'h05
`define DIV_HIGH 4'h2
`define DIV_MID 4'h8
`endif

// file: core/cpu_flag_pkg.sv
// shared types of the status flag and arithmetic core
package cpu_flag_pkg;
  typedef enum logic {ST_IDLE, ST_EXEC} exec_state_t;
  typedef logic [4:0] opcode_t;
  typedef logic [7:0] byte_t;
endpackage

// file: core/phi_divider.sv
// internal cycle clock tick derived from the main oscillator input
`timescale 1ns/1ps
`default_nettype none
`include "cpu_flag_regs.svh"
module phi_divider (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic high_speed_in,
  input wire logic restart_in,
  // tick, one cycle per cycle-clock period
  output logic tick_out
);
  logic [3:0] cnt_r;
  logic [3:0] last;

  // high-speed mode halves the main oscillator input
  assign last = high_speed_in ? (`DIV_HIGH - 4'h1) : (`DIV_MID - 4'h1);
  assign tick_out = (cnt_r == last);

  // restart aligns the phase to an instruction start
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 4'h0;
    end else if (restart_in || cnt_r >= last) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: core/bcd_adder.sv
// binary or packed decimal add and subtract with carry
`timescale 1ns/1ps
`default_nettype none
module bcd_adder (
  // operands
  input wire cpu_flag_pkg::byte_t a_in,
  input wire cpu_flag_pkg::byte_t b_in,
  input wire logic carry_in,
  // mode
  input wire logic sub_in,
  input wire logic dec_in,
  // result
  output var cpu_flag_pkg::byte_t sum_out,
  output logic carry_out,
  output logic ovf_out
);
  import cpu_flag_pkg::*;

  logic [7:0] b_eff;
  logic [8:0] bin;
  logic [4:0] lo;
  logic [4:0] hi;
  logic lo_c;

  always_comb begin
    b_eff = sub_in ? ~b_in : b_in;
    bin = {1'b0, a_in} + {1'b0, b_eff} + {8'h00, carry_in};
    lo = 5'h00;
    hi = 5'h00;
    lo_c = 1'b0;
    sum_out = bin[7:0];
    carry_out = bin[8];
    if (dec_in && !sub_in) begin
      // decimal add: adjust each digit above nine
      lo = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
      lo_c = (lo > 5'h09);
      if (lo_c) lo = lo + 5'h06;
      hi = {1'b0, a_in[7:4]} + {1'b0, b_in[7:4]} + {4'h0, lo_c};
      carry_out = (hi > 5'h09);
      if (carry_out) hi = hi + 5'h06;
      sum_out = {hi[3:0], lo[3:0]};
    end else if (dec_in) begin
      // decimal subtract: carry set means no borrow
      lo = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, ~carry_in};
      lo_c = lo[4];
      if (lo_c) lo = lo - 5'h06;
      hi = {1'b0, a_in[7:4]} - {1'b0, b_in[7:4]} - {4'h0, lo_c};
      carry_out = ~hi[4];
      if (hi[4]) hi = hi - 5'h06;
      sum_out = {hi[3:0], lo[3:0]};
    end
    // binary overflow; meaningless in decimal mode
    ovf_out = (a_in[7] == b_eff[7]) && (bin[7] != a_in[7]);
  end
endmodule
`default_nettype wire

// file: tb/cpu_status_flags_and_arith_bench.sv
// self-checking bench of the status flag and arithmetic core
`timescale 1ns/1ps
`default_nettype none
`include "cpu_flag_regs.svh"
module cpu_status_flags_and_arith_bench;
  import cpu_flag_pkg::*;
  typedef struct packed {
    logic t;
    logic d;
    logic c;
    opcode_t op;
    byte_t a;
    byte_t b;
    byte_t res;
    logic c_out;
  } alu_row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  byte_t wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  byte_t rdata;
  logic busy;
  byte_t psw;
  logic phi;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // t d c op a b result carry; logic rows keep carry
  alu_row_t rows [10] = '{
    '{1'b0, 1'b0, 1'b0, 5'h01, 8'h15, 8'h27, 8'h3C, 1'b0},
    '{1'b0, 1'b1, 1'b0, 5'h01, 8'h15, 8'h27, 8'h42, 1'b0},
    '{1'b0, 1'b1, 1'b1, 5'h01, 8'h99, 8'h00, 8'h00, 1'b1},
    '{1'b0, 1'b1, 1'b1, 5'h02, 8'h42, 8'h15, 8'h27, 1'b1},
    '{1'b0, 1'b1, 1'b1, 5'h02, 8'h10, 8'h20, 8'h90, 1'b0},
    '{1'b0, 1'b0, 1'b1, 5'h02, 8'h10, 8'h20, 8'hF0, 1'b0},
    '{1'b1, 1'b0, 1'b1, 5'h03, 8'hF0, 8'h3C, 8'h30, 1'b1},
    '{1'b1, 1'b1, 1'b0, 5'h04, 8'hF0, 8'h0C, 8'hFC, 1'b0},
    '{1'b0, 1'b0, 1'b1, 5'h05, 8'hFF, 8'h0F, 8'hF0, 1'b1},
    '{1'b1, 1'b1, 1'b0, 5'h01, 8'h58, 8'h46, 8'h04, 1'b1}
  };

  cpu_flag_core i_dut (
    .CLK_SYS_IN(clk_sys),
    .RST_N_IN(rst_n),
    .ADDR_IN(addr),
    .WDATA_IN(wdata),
    .WR_IN(wr),
    .RD_IN(rd),
    .RDATA_OUT(rdata),
    .BUSY_OUT(busy),
    .PSW_OUT(psw),
    .PHI_OUT(phi)
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // whole run needs well under 3000 clocks
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input byte_t got_v, input byte_t exp_v);
    comparisons++;
    if (got_v !== exp_v) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  // tasks start and end just after an edge, so strobes never collide
  task automatic reg_wr(input logic [2:0] a, input byte_t d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [2:0] a, output byte_t d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // clocks from the command edge until busy drops
  task automatic exec(input opcode_t op, output int k);
    reg_wr(`OFF_CMD, {3'h0, op});
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (busy !== 1'b0 && k < 300);
  endtask

  task automatic phi_gap(output int k);
    k = 0;
    while (phi !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (phi !== 1'b1 && k < 20);
  endtask

  task automatic alu_case(input alu_row_t r);
    byte_t got;
    int k;
    reg_wr(`OFF_PSW, {2'b00, r.t, 1'b0, r.d, 2'b00, r.c});
    // in index-X rows the accumulator gets the inverse so a wrong source shows
    reg_wr(`OFF_ACC, r.t ? ~r.a : r.a);
    reg_wr(`OFF_MEMX, r.a);
    reg_wr(`OFF_OPND, r.b);
    exec(r.op, k);
    check(8'(k), r.t ? 8'h0A : 8'h04);
    reg_rd(r.t ? `OFF_MEMX : `OFF_ACC, got);
    check(got, r.res);
    if (r.t) begin
      reg_rd(`OFF_ACC, got);
      check(got, ~r.a);
    end
    check({7'h00, psw[`PSW_C]}, {7'h00, r.c_out});
  endtask

  initial begin
    byte_t got;
    int k;
    int fb [4];
    fb = '{`PSW_C, `PSW_D, `PSW_T, `PSW_I};
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check(psw, `PSW_RST);
    check({7'h00, busy}, 8'h00);
    reg_rd(`OFF_CTRL, got);
    check(got, `CTRL_RST);
    @(posedge clk_sys);
    #1;
    check(rdata, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      alu_case(rows[i]);
    end
    $display("test alu table done");
    // decimal add, one spacer, then every flag opcode
    reg_wr(`OFF_PSW, 8'h08);
    reg_wr(`OFF_ACC, 8'h38);
    reg_wr(`OFF_OPND, 8'h25);
    exec(`OP_ADD_CARRY, k);
    exec(`OP_NOP, k);
    check(8'(k), 8'h04);
    for (int i = 0; i < 8; i++) begin
      exec(opcode_t'(i + 6), k);
      check(8'(k), 8'h04);
      check({7'h00, psw[fb[i / 2]]}, {7'h00, ~i[0]});
    end
    reg_rd(`OFF_ACC, got);
    check(got, 8'h63);
    $display("test flag opcodes done");
    // mode flags set on purpose: product and quotient must ignore them
    reg_wr(`OFF_PSW, 8'h6B);
    reg_wr(`OFF_ACC, 8'h12);
    reg_wr(`OFF_OPND, 8'h34);
    reg_wr(`OFF_MEMX, 8'h77);
    exec(`OP_PRODUCT, k);
    check(8'(k), 8'h1E);
    check(psw, 8'h6B);
    reg_rd(`OFF_ACC, got);
    check(got, 8'hA8);
    reg_rd(`OFF_HIGH, got);
    check(got, 8'h03);
    reg_wr(`OFF_ACC, 8'hA9);
    exec(`OP_QUOTIENT, k);
    check(8'(k), 8'h20);
    check(psw, 8'h6B);
    reg_rd(`OFF_ACC, got);
    check(got, 8'h12);
    reg_rd(`OFF_HIGH, got);
    check(got, 8'h01);
    reg_rd(`OFF_MEMX, got);
    check(got, 8'h77);
    $display("test multiply divide done");
    // bit 3 of the request register, tested after one spacer instruction
    reg_wr(`OFF_CTRL, 8'h07);
    reg_wr(`OFF_IRQ, 8'h08);
    exec(`OP_NOP, k);
    exec(`OP_BRANCH_SET, k);
    check(8'(k), 8'h0A);
    reg_rd(`OFF_CMD, got);
    check(got, 8'h02);
    exec(`OP_BRANCH_CLR, k);
    reg_rd(`OFF_CMD, got);
    check(got, 8'h00);
    reg_wr(`OFF_IRQ, 8'h00);
    reg_rd(`OFF_IRQ, got);
    check(got, 8'h08);
    exec(`OP_NOP, k);
    reg_rd(`OFF_IRQ, got);
    check(got, 8'h00);
    exec(`OP_BRANCH_CLR, k);
    reg_rd(`OFF_CMD, got);
    check(got, 8'h02);
    $display("test request delay done");
    phi_gap(k);
    check(8'(k), 8'h02);
    reg_wr(`OFF_CTRL, 8'h06);
    phi_gap(k);
    check(8'(k), 8'h08);
    exec(`OP_NOP, k);
    check(8'(k), 8'h10);
    reg_rd(`OFF_CTRL, got);
    check(got, 8'h06);
    $display("test cycle clock done");
    // second reset with the mask flag cleared beforehand
    reg_wr(`OFF_PSW, 8'hFB);
    check(psw, 8'hFB);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check(psw, `PSW_RST);
    check({7'h00, busy}, 8'h00);
    reg_rd(`OFF_CTRL, got);
    check(got, `CTRL_RST);
    $display("test second reset done");
    final_report();
  end
endmodule
`default_nettype wire
